// ---- hw/link_csr_slave_port.v ----
// Contract
// - No bursts, wait-request always zero
// - 32-bit data, word addressed
// - No byte enables, full-word writes
// - Writes zero wait, reads one-cycle latency
// - Fixed read-only bits constant, ignore writes
// - Variable read-only bits show live value
// - Read-clear bits clear after read
// - Read-write bits store written value
// - Write-one-clear: hardware sets, writing one clears
// - Clear beats simultaneous hardware set
// - Write-one-set: software sets, hardware clears
// - Set beats simultaneous hardware clear
// - Common control at zero; bits 31:3 zero
// - Bit 2 spare storage, resets zero
// - Bit 1 reports build bit order
// - Bit 0 reports build octet order
// - Octet order one reverses octets
// - Build-time fields ignore writes
`timescale 1ns/1ps
`include "link_csr_map.vh"

module link_csr_slave_port #(
    parameter OCTET_ORDER = 1'b0,
    parameter BIT_ORDER = 1'b0
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    input wire [`EVENT_W-1:0] event_set_hw,
    input wire [`EVENT_W-1:0] request_done_hw,
    input wire [`EVENT_W-1:0] live_state,
    input wire [31:0] tx_word_in,
    output reg [31:0] tx_word_out,
    output wire lane_spare_storage
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg spare_reg;
    reg [`EVENT_W-1:0] write_one_clear_reg;
    reg [`EVENT_W-1:0] write_one_set_reg;
    reg [`EVENT_W-1:0] snapshot_reg;
    reg [31:0] read_word_next;
    wire [31:0] ordered_word;
    wire wr_common;
    wire wr_status;
    wire wr_set;
    wire rd_snapshot;

    // No wait states ever; reads return on the next edge
    assign waitrequest = 1'b0;
    assign lane_spare_storage = spare_reg;

    // Decodes compare the full word address, so aliases cannot occur
    assign wr_common = write && (address == `COMMON_LANE_CONTROL_ADDR);
    assign wr_status = write && (address == `EVENT_STATUS_ADDR);
    assign wr_set = write && (address == `EVENT_SET_ADDR);
    assign rd_snapshot = read && (address == `EVENT_SNAPSHOT_ADDR);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Bits not listed stay zero; unmapped addresses read zero
    always @* begin
        read_word_next = 32'h00000000;
        case (address)
            `COMMON_LANE_CONTROL_ADDR: begin
                read_word_next[`SPARE_BIT] = spare_reg;
                read_word_next[`BIT_ORDER_BIT] = BIT_ORDER;
                read_word_next[`OCTET_ORDER_BIT] = OCTET_ORDER;
            end
            `EVENT_STATUS_ADDR: begin
                read_word_next[`EVENT_W-1:0] = write_one_clear_reg;
                read_word_next[`EVENT_W+3:`EVENT_W] = live_state;
            end
            `EVENT_SET_ADDR: begin
                read_word_next[`EVENT_W-1:0] = write_one_set_reg;
            end
            `EVENT_SNAPSHOT_ADDR: begin
                read_word_next[`EVENT_W-1:0] = snapshot_reg;
            end
            default: begin
                read_word_next = 32'h00000000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registered read data, one cycle after the read strobe
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            readdata <= 32'h00000000;
        end else if (read) begin
            readdata <= read_word_next;
        end
    end

    // ----------------------------------------------------------------
    // Writable state
    // ----------------------------------------------------------------
    // Whole word taken; only bit 2 stores, build-time bits ignore writes
    always @(posedge clk_sys) begin
        if (rst) begin
            spare_reg <= `SPARE_RESET;
        end else if (wr_common) begin
            spare_reg <= writedata[`SPARE_BIT];
        end
    end

    // Hardware set, software clear wins the tie
    always @(posedge clk_sys) begin
        if (rst) begin
            write_one_clear_reg <= `EVENT_RESET;
        end else begin
            write_one_clear_reg <= (write_one_clear_reg | event_set_hw) &
                ~({`EVENT_W{wr_status}} & writedata[`EVENT_W-1:0]);
        end
    end

    // Software set, hardware clear loses the tie
    always @(posedge clk_sys) begin
        if (rst) begin
            write_one_set_reg <= `EVENT_RESET;
        end else begin
            write_one_set_reg <= (write_one_set_reg & ~request_done_hw) |
                ({`EVENT_W{wr_set}} & writedata[`EVENT_W-1:0]);
        end
    end

    // Captures hardware events; a read clears, but an event that same cycle survives
    always @(posedge clk_sys) begin
        if (rst) begin
            snapshot_reg <= `EVENT_RESET;
        end else if (rd_snapshot) begin
            snapshot_reg <= event_set_hw;
        end else begin
            snapshot_reg <= snapshot_reg | event_set_hw;
        end
    end

    // ----------------------------------------------------------------
    // Transmit word ordering per build options
    // ----------------------------------------------------------------
    tx_word_order #(
        .OCTET_REVERSE(OCTET_ORDER),
        .BIT_REVERSE(BIT_ORDER)
    ) u_order (
        .word_in(tx_word_in),
        .word_out(ordered_word)
    );

    // Registered so the serializer sees a clean word
    always @(posedge clk_sys) begin
        if (rst) begin
            tx_word_out <= 32'h00000000;
        end else begin
            tx_word_out <= ordered_word;
        end
    end
endmodule

// ---- shared/link_csr_map.vh ----
`ifndef LINK_CSR_MAP_VH
`define LINK_CSR_MAP_VH

// ----------------------------------------------------------------
// Register map, word addresses
// ----------------------------------------------------------------
`define ADDR_W 8
`define COMMON_LANE_CONTROL_ADDR 8'h00
`define EVENT_STATUS_ADDR 8'h01
`define EVENT_SET_ADDR 8'h02
`define EVENT_SNAPSHOT_ADDR 8'h03

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define OCTET_ORDER_BIT 0
`define BIT_ORDER_BIT 1
`define SPARE_BIT 2
`define SPARE_RESET 1'h0
`define EVENT_W 4
`define EVENT_RESET 4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WRITE_STALL_CYCLES 0
`define READ_STALL_CYCLES 1
`define READ_RETURN_DELAY 1

`endif

// ---- hw/tx_word_order.v ----
`timescale 1ns/1ps

// Applies the build-time octet and bit order to one 32-bit transmit word.
module tx_word_order #(
    parameter OCTET_REVERSE = 1'b0,
    parameter BIT_REVERSE = 1'b0
) (
    input wire [31:0] word_in,
    output wire [31:0] word_out
);
    wire [31:0] octet_word;
    wire [31:0] mirror_word;

    // Octet swap then bit mirror
    assign octet_word = OCTET_REVERSE ?
        {word_in[7:0], word_in[15:8], word_in[23:16], word_in[31:24]} : word_in;

    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_mirror
            assign mirror_word[i] = octet_word[31 - i];
        end
    endgenerate

    assign word_out = BIT_REVERSE ? mirror_word : octet_word;
endmodule

// ---- tb/link_csr_monitor.sv ----
`timescale 1ns/1ps
module link_csr_monitor #(
    parameter OCTET_ORDER = 1'b0,
    parameter BIT_ORDER = 1'b0
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire [3:0] live_state,
    input wire [31:0] tx_word_in,
    input wire [31:0] tx_word_out,
    input wire lane_spare_storage
);
    // ----------------------------------------
    // Port checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Expected wire order: octet swap first, then full mirror
    function automatic logic [31:0] ord(logic [31:0] w);
        logic [31:0] o;
        o = OCTET_ORDER ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
        return BIT_ORDER ? {<<{o}} : o;
    endfunction
    property p_nowait; waitrequest == 1'b0; endproperty
    a_nowait: assert property (p_nowait) else $error("wait request raised");
    property p_stand; !read |=> $stable(readdata); endproperty
    a_stand: assert property (p_stand) else $error("read data moved");
    property p_ctrl; read && address == 8'h00 |=> readdata ==
        {29'h0, lane_spare_storage, BIT_ORDER[0], OCTET_ORDER[0]}; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control word wrong");
    property p_spwr; write && address == 8'h00 |=> lane_spare_storage == $past(writedata[2]);
    endproperty
    a_spwr: assert property (p_spwr) else $error("spare not written");
    property p_sphold; !(write && address == 8'h00) |=> $stable(lane_spare_storage); endproperty
    a_sphold: assert property (p_sphold) else $error("spare changed");
    property p_unm; read && address > 8'h03 |=> readdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_live; read && address == 8'h01 |=> readdata[7:4] == $past(live_state); endproperty
    a_live: assert property (p_live) else $error("live status wrong");
    property p_tx; 1'b1 |=> tx_word_out == ord($past(tx_word_in)); endproperty
    a_tx: assert property (p_tx) else $error("transmit order wrong");
endmodule
bind link_csr_slave_port link_csr_monitor #(.OCTET_ORDER(OCTET_ORDER), .BIT_ORDER(BIT_ORDER))
    mon (.*);

// ---- tb/csr_master.sv ----
`timescale 1ns/1ps
// Bus master; takes byte offsets and drops the two low bits
module csr_master (
    input wire clk_sys,
    output logic [7:0] address = 8'h00,
    output logic read = 1'b0,
    output logic write = 1'b0,
    output logic [31:0] writedata = 32'h0,
    input wire [31:0] readdata
);
    task wr(input [9:0] a, input [31:0] d);
        @(posedge clk_sys);
        address <= a[9:2];
        writedata <= d;
        write <= 1'b1;
        @(posedge clk_sys);
        write <= 1'b0;
        writedata <= ~d; // Stale data must not be relied on
    endtask
    task rd(input [9:0] a, output [31:0] q);
        @(posedge clk_sys);
        address <= a[9:2];
        read <= 1'b1;
        @(posedge clk_sys);
        read <= 1'b0;
        #1 q = readdata;
    endtask
endmodule

// ---- tb/link_csr_slave_port_test.sv ----
`timescale 1ns/1ps
`include "link_csr_map.vh"
`define CHK(a, b) n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("FAIL %0t %h %h", $time, a, b); end
module link_csr_slave_port_test;
    logic clk_sys = 0, rst = 1;
    logic [3:0] event_set_hw = 0, request_done_hw = 0, live_state = 0;
    logic [31:0] tx_word_in = 0, readdata, tx_word_out, q, d, writedata;
    logic [7:0] address;
    logic read, write, waitrequest, lane_spare_storage;
    integer err_total = 0, n_compared = 0, cyc = 0, i;
    // Both order options on together, as an integrator must build it
    link_csr_slave_port #(.OCTET_ORDER(1'b1), .BIT_ORDER(1'b1)) dut (.clk_sys, .rst,
        .address, .read, .write, .writedata, .readdata, .waitrequest, .event_set_hw,
        .request_done_hw, .live_state, .tx_word_in, .tx_word_out, .lane_spare_storage);
    csr_master m (.clk_sys, .address, .read, .write, .writedata, .readdata);
    always #10 clk_sys = ~clk_sys;
    // Random traffic on live and transmit inputs; hang guard
    always @(posedge clk_sys) begin
        tx_word_in <= $urandom;
        live_state <= $urandom;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            summarize;
        end
    end
    // Expected control word: reserved zero, spare from the write, both build options on
    function automatic logic [31:0] exp_ctrl(input logic spare);
        exp_ctrl = {29'h0, spare, 1'b1, 1'b1};
    endfunction
    task summarize;
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One-cycle hardware set and clear pulses
    task hw(input [3:0] e, input [3:0] c);
        @(posedge clk_sys);
        event_set_hw <= e;
        request_done_hw <= c;
        @(posedge clk_sys);
        event_set_hw <= 4'h0;
        request_done_hw <= 4'h0;
    endtask
    initial begin
        i = $urandom(37207);
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        m.rd(0, q); `CHK(q, exp_ctrl(1'b0))
        d = $urandom; m.wr(0, d); m.rd(0, q); `CHK(q, exp_ctrl(d[2]))
        d = ~d; m.wr(0, d); m.rd(0, q); `CHK(q, exp_ctrl(d[2]))
        hw(4'hF, 4'h0); m.rd(4, q); `CHK(q[3:0], 4'hF)
        m.wr(4, 32'h5); m.rd(4, q); `CHK(q[3:0], 4'hA)
        fork m.wr(4, 32'h2); hw(4'h3, 4'h0); join
        m.rd(4, q); `CHK(q[3:0], 4'h9)
        m.rd(12, q); `CHK(q[3:0], 4'hF)
        m.rd(12, q); `CHK(q[3:0], 4'h0)
        m.wr(8, 32'h6); m.wr(8, 32'h0); m.rd(8, q); `CHK(q[3:0], 4'h6)
        fork m.wr(8, 32'h1); hw(4'h0, 4'h3); join
        m.rd(8, q); `CHK(q[3:0], 4'h5)
        repeat (8) begin
            i = 16 + 4 * ($urandom % 252);
            m.wr(i, $urandom); m.rd(i, q); `CHK(q, 32'h0)
        end
        summarize;
    end
endmodule
